// File: rtl/scd_cfg.svh
`ifndef SCD_CFG_SVH
`define SCD_CFG_SVH
// Register byte offsets
`define SCD_OFS_DIVIDE     12'h000
`define SCD_OFS_SYNC_CTRL  12'h004
`define SCD_OFS_POWER      12'h008
`define SCD_OFS_STATUS     12'h00c
// Field positions
`define SCD_SYNC_EN_BIT    1
`define SCD_SYNC_ONCE_BIT  2
`define SCD_STAB_EN_BIT    0
`define SCD_STAB_OVR_BIT   1
// Reset values
`define SCD_DIVIDE_RST     3'h0
`define SCD_SYNC_RST       3'h0
`define SCD_POWER_RST      2'h0
`define SCD_STAB_RST       2'h0
// Divider ratio limits
`define SCD_RATIO_MIN      1
`define SCD_RATIO_MAX      8
// Stabiliser timing
`define SCD_CLK_MHZ        20
`define SCD_STAB_MIN_MHZ   20
`define SCD_RELOCK_NS      5000
`define SCD_RELOCK_CYC     ((`SCD_RELOCK_NS * `SCD_CLK_MHZ) / 1000)
// Wake-up count limits
`define SCD_WAKE_MAX       16'hffff
`define SCD_STBY_WAKE      16'h0004
`endif

// File: rtl/scd_pkg.sv
package scd_pkg;
  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_STANDBY,
    PWR_DOWN,
    PWR_WAKE
  } scd_pwr_t;

  typedef struct packed {
    logic       sync_en;
    logic       sync_once;
    logic [2:0] ratio_code;
  } scd_clk_cfg_t;

  typedef struct packed {
    logic reference_on;
    logic bias_on;
    logic clock_on;
    logic outputs_on;
  } scd_pwr_ctl_t;
endpackage

// File: rtl/scd_regfile.sv
`timescale 1ns/1ps
`include "scd_cfg.svh"
module scd_regfile
  import scd_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // Write port
  input  wire logic        i_we,
  input  wire logic [1:0]  i_waddr,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  // Read port
  input  wire logic [1:0]  i_raddr,
  input  wire logic [31:0] i_status,
  output logic      [31:0] o_rdata,
  // Stored fields
  output logic      [2:0]  o_ratio_code,
  output logic      [2:0]  o_sync_bits,
  output logic      [1:0]  o_power_bits,
  output logic      [1:0]  o_stab_bits
);
  logic [2:0]  ratio_ff;
  logic [2:0]  nxt_ratio;
  logic [2:0]  sync_ff;
  logic [2:0]  nxt_sync;
  logic [1:0]  power_ff;
  logic [1:0]  nxt_power;
  logic [1:0]  stab_ff;
  logic [1:0]  nxt_stab;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  always_comb
  begin
    nxt_ratio = ratio_ff;
    nxt_sync  = sync_ff;
    nxt_power = power_ff;
    nxt_stab  = stab_ff;
    if (i_we && i_wstrb[0])
    begin
      case (i_waddr)
        2'h0:    nxt_ratio = i_wdata[2:0];
        2'h1:    nxt_sync  = i_wdata[2:0];
        2'h2:    nxt_power = i_wdata[1:0];
        2'h3:    nxt_stab  = i_wdata[1:0];
        default: nxt_ratio = ratio_ff;
      endcase
    end
    case (i_raddr)
      2'h0:    nxt_rdata = {29'h0, ratio_ff};
      2'h1:    nxt_rdata = {29'h0, sync_ff};
      2'h2:    nxt_rdata = {30'h0, power_ff};
      2'h3:    nxt_rdata = {i_status[31:2], stab_ff};
      default: nxt_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      ratio_ff <= `SCD_DIVIDE_RST;
      sync_ff  <= `SCD_SYNC_RST;
      power_ff <= `SCD_POWER_RST;
      stab_ff  <= `SCD_STAB_RST;
      rdata_ff <= 32'h0;
    end
    else
    begin
      ratio_ff <= nxt_ratio;
      sync_ff  <= nxt_sync;
      power_ff <= nxt_power;
      stab_ff  <= nxt_stab;
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_ratio_code = ratio_ff;
  assign o_sync_bits  = sync_ff;
  assign o_power_bits = power_ff;
  assign o_stab_bits  = stab_ff;
  assign o_rdata      = rdata_ff;
endmodule

// File: rtl/scd_top.sv
// Function
// - Divide the sample clock by a programmed integer from 1 to 8.
// - Two bits choose realign on every sync or first sync after write.
// - An accepted sync returns the divider to its initial state.
// - Sync input passes a two-stage synchroniser before acting.
// - Stabiliser makes the internal clock high for half its period.
// - Stabiliser need not operate below about 20 MHz input clock.
// - Power-down entered from register command or high power-down pin.
// - Output drivers are disabled while powered down.
// - Low power-down pin returns the device to normal operation.
// - Power-down stops reference, bias, clock; wake time tracks down time.
// - Register standby keeps reference powered for quicker wake-up.
// - Strap pin low disables stabiliser, high enables; enabled by default.
`timescale 1ns/1ps
`include "scd_cfg.svh"
module scd_top
  import scd_pkg::*;
(
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RESET,
  // AXI4-Lite write address
  input  wire logic [11:0] I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  // AXI4-Lite write response
  output logic      [1:0]  O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  // AXI4-Lite read address
  input  wire logic [11:0] I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  // AXI4-Lite read data
  output logic      [31:0] O_RDATA,
  output logic      [1:0]  O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  // Pins
  input  wire logic        I_SYNC,
  input  wire logic        I_POWER_DOWN_PIN,
  input  wire logic        I_SERIAL_IO_STABILISER_STRAP,
  // Clock and power outputs
  output logic             O_SAMPLE_CLK,
  output logic             O_SAMPLE_STROBE,
  output logic             O_DUTY_CYCLE_STABILISER,
  output logic             O_REFERENCE_ON,
  output logic             O_BIAS_ON,
  output logic             O_CLOCK_ON,
  output logic             O_OUTPUT_ENABLE
);
  localparam logic STAB_RATE_OK = (`SCD_CLK_MHZ >= `SCD_STAB_MIN_MHZ);

  // Bus slave state
  logic        aw_ff,   nxt_aw;
  logic [11:0] awa_ff,  nxt_awa;
  logic        w_ff,    nxt_w;
  logic [31:0] wd_ff,   nxt_wd;
  logic [3:0]  ws_ff,   nxt_ws;
  logic        bv_ff,   nxt_bv;
  logic [1:0]  br_ff,   nxt_br;
  logic        ar_ff,   nxt_ar;
  logic [11:0] ara_ff,  nxt_ara;
  logic        rv_ff,   nxt_rv;
  logic [1:0]  rr_ff,   nxt_rr;
  logic        awrdy_ff, nxt_awrdy;
  logic        wrdy_ff,  nxt_wrdy;
  logic        ardy_ff,  nxt_ardy;
  logic [31:0] rdat_ff,  nxt_rdat;
  logic        wr_go;
  logic        rd_go;
  logic [31:0] rf_rdata;
  logic [31:0] status;
  logic [2:0]  ratio_code;
  logic [2:0]  sync_bits;
  logic [1:0]  power_bits;
  logic [1:0]  stab_bits;

  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a[11:4] == 8'h0);
  endfunction

  always_comb
  begin
    nxt_aw  = aw_ff;
    nxt_awa = awa_ff;
    nxt_w   = w_ff;
    nxt_wd  = wd_ff;
    nxt_ws  = ws_ff;
    nxt_bv  = bv_ff;
    nxt_br  = br_ff;
    nxt_ar  = ar_ff;
    nxt_ara = ara_ff;
    nxt_rv  = rv_ff;
    nxt_rr  = rr_ff;
    nxt_rdat = rdat_ff;
    wr_go   = 1'b0;
    rd_go   = 1'b0;
    if (I_AWVALID && !aw_ff && !bv_ff)
    begin
      nxt_aw  = 1'b1;
      nxt_awa = I_AWADDR;
    end
    if (I_WVALID && !w_ff && !bv_ff)
    begin
      nxt_w  = 1'b1;
      nxt_wd = I_WDATA;
      nxt_ws = I_WSTRB;
    end
    if (aw_ff && w_ff && !bv_ff)
    begin
      wr_go  = addr_ok(awa_ff);
      nxt_aw = 1'b0;
      nxt_w  = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = addr_ok(awa_ff) ? 2'h0 : 2'h2;
    end
    if (bv_ff && I_BREADY)
      nxt_bv = 1'b0;
    if (I_ARVALID && !ar_ff && !rv_ff)
    begin
      nxt_ar  = 1'b1;
      nxt_ara = I_ARADDR;
    end
    if (ar_ff)
    begin
      rd_go  = 1'b1;
      nxt_ar = 1'b0;
    end
    if (rd_go)
    begin
      nxt_rv = 1'b1;
      nxt_rr = addr_ok(ara_ff) ? 2'h0 : 2'h2;
      nxt_rdat = addr_ok(ara_ff) ? rf_rdata : 32'h0;
    end
    if (rv_ff && I_RREADY)
      nxt_rv = 1'b0;
    // Readies are registered copies of the next idle state
    nxt_awrdy = !nxt_aw && !nxt_bv;
    nxt_wrdy  = !nxt_w && !nxt_bv;
    nxt_ardy  = !nxt_ar && !nxt_rv;
  end

  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      aw_ff  <= 1'b0;
      awa_ff <= 12'h0;
      w_ff   <= 1'b0;
      wd_ff  <= 32'h0;
      ws_ff  <= 4'h0;
      bv_ff  <= 1'b0;
      br_ff  <= 2'h0;
      ar_ff  <= 1'b0;
      ara_ff <= 12'h0;
      rv_ff  <= 1'b0;
      rr_ff  <= 2'h0;
      awrdy_ff <= 1'b1;
      wrdy_ff  <= 1'b1;
      ardy_ff  <= 1'b1;
      rdat_ff  <= 32'h0;
    end
    else
    begin
      aw_ff  <= nxt_aw;
      awa_ff <= nxt_awa;
      w_ff   <= nxt_w;
      wd_ff  <= nxt_wd;
      ws_ff  <= nxt_ws;
      bv_ff  <= nxt_bv;
      br_ff  <= nxt_br;
      ar_ff  <= nxt_ar;
      ara_ff <= nxt_ara;
      rv_ff  <= nxt_rv;
      rr_ff  <= nxt_rr;
      awrdy_ff <= nxt_awrdy;
      wrdy_ff  <= nxt_wrdy;
      ardy_ff  <= nxt_ardy;
      rdat_ff  <= nxt_rdat;
    end
  end

  scd_regfile u_regs (
    .i_clk        (I_CLK),
    .i_reset      (I_RESET),
    .i_we         (wr_go),
    .i_waddr      (awa_ff[3:2]),
    .i_wdata      (wd_ff),
    .i_wstrb      (ws_ff),
    .i_raddr      (nxt_ara[3:2]),
    .i_status     (status),
    .o_rdata      (rf_rdata),
    .o_ratio_code (ratio_code),
    .o_sync_bits  (sync_bits),
    .o_power_bits (power_bits),
    .o_stab_bits  (stab_bits)
  );

  // Sync synchroniser, divider and realign control
  logic [2:0]  sy_ff;
  logic [2:0]  nxt_sy;
  logic        armed_ff, nxt_armed;
  logic [2:0]  cnt_ff,   nxt_cnt;
  logic        sclk_ff,  nxt_sclk;
  logic        stb_ff,   nxt_stb;
  logic        sync_rise;
  logic        sync_take;
  logic [3:0]  ratio_n;
  logic [2:0]  half_n;
  logic        sync_wr;
  scd_pwr_ctl_t ctl;
  logic        stab_on;

  assign sync_wr   = wr_go && (awa_ff == `SCD_OFS_SYNC_CTRL) && ws_ff[0];
  assign sync_rise = sy_ff[1] && !sy_ff[2];
  assign ratio_n   = {1'b0, ratio_code} + 4'h1;
  assign half_n    = ratio_n[3:1];
  assign sync_take = sync_rise && sync_bits[`SCD_SYNC_EN_BIT]
                     && (!sync_bits[`SCD_SYNC_ONCE_BIT] || armed_ff);

  always_comb
  begin
    nxt_sy    = {sy_ff[1:0], I_SYNC};
    nxt_armed = armed_ff;
    if (sync_take)
      nxt_armed = 1'b0;
    if (sync_wr)
      nxt_armed = 1'b1;
    nxt_stb  = 1'b0;
    nxt_cnt  = cnt_ff;
    nxt_sclk = sclk_ff;
    if (!ctl.clock_on || sync_take)
    begin
      nxt_cnt  = 3'h0;
      nxt_sclk = 1'b0;
    end
    else
    begin
      if (cnt_ff >= ratio_code)
        nxt_cnt = 3'h0;
      else
        nxt_cnt = cnt_ff + 3'h1;
      if (nxt_cnt == 3'h0)
      begin
        nxt_sclk = 1'b1;
        nxt_stb  = 1'b1;
      end
      else if (stab_on ? ({1'b0, nxt_cnt} == {1'b0, half_n}) : (nxt_cnt == 3'h1))
        nxt_sclk = (ratio_code == 3'h0);
    end
  end

  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      sy_ff    <= 3'h0;
      armed_ff <= 1'b0;
      cnt_ff   <= 3'h0;
      sclk_ff  <= 1'b0;
      stb_ff   <= 1'b0;
    end
    else
    begin
      sy_ff    <= nxt_sy;
      armed_ff <= nxt_armed;
      cnt_ff   <= nxt_cnt;
      sclk_ff  <= nxt_sclk;
      stb_ff   <= nxt_stb;
    end
  end

  // Power control and stabiliser enable
  scd_pwr_t     pwr_ff, nxt_pwr;
  logic [15:0]  down_ff, nxt_down;
  logic         pwr_req;
  logic         stby_req;

  assign pwr_req  = I_POWER_DOWN_PIN || power_bits[0];
  assign stby_req = power_bits[1];
  // Strap picks the stabiliser state unless software overrides it
  assign stab_on  = STAB_RATE_OK && (stab_bits[`SCD_STAB_OVR_BIT] ? stab_bits[`SCD_STAB_EN_BIT]
                    : I_SERIAL_IO_STABILISER_STRAP);
  assign status   = {12'h0, down_ff, pwr_ff, 2'h0};

  always_comb
  begin
    nxt_pwr  = pwr_ff;
    nxt_down = down_ff;
    case (pwr_ff)
      PWR_RUN:
      begin
        nxt_down = 16'h0;
        if (pwr_req)
          nxt_pwr = PWR_DOWN;
        else if (stby_req)
          nxt_pwr = PWR_STANDBY;
      end
      PWR_STANDBY:
      begin
        if (pwr_req)
          nxt_pwr = PWR_DOWN;
        else if (!stby_req)
        begin
          nxt_pwr  = PWR_WAKE;
          nxt_down = `SCD_STBY_WAKE;
        end
      end
      PWR_DOWN:
      begin
        if (down_ff != `SCD_WAKE_MAX)
          nxt_down = down_ff + 16'h1;
        if (!pwr_req)
          nxt_pwr = stby_req ? PWR_STANDBY : PWR_WAKE;
      end
      PWR_WAKE:
      begin
        if (pwr_req)
          nxt_pwr = PWR_DOWN;
        else if (down_ff == 16'h0)
          nxt_pwr = PWR_RUN;
        else
          nxt_down = down_ff - 16'h1;
      end
      default: nxt_pwr = PWR_RUN;
    endcase
    ctl.reference_on = (pwr_ff != PWR_DOWN);
    ctl.bias_on      = (pwr_ff == PWR_RUN) || (pwr_ff == PWR_WAKE);
    ctl.clock_on     = (pwr_ff == PWR_RUN);
    ctl.outputs_on   = (pwr_ff == PWR_RUN);
  end

  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      pwr_ff  <= PWR_RUN;
      down_ff <= 16'h0;
    end
    else
    begin
      pwr_ff  <= nxt_pwr;
      down_ff <= nxt_down;
    end
  end

  // Registered outputs
  logic [6:0] out_ff;
  always_ff @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
      out_ff <= 7'h0;
    else
      out_ff <= {stab_on, ctl.reference_on, ctl.bias_on, ctl.clock_on,
                 ctl.outputs_on, 2'h0};
  end

  assign O_AWREADY  = awrdy_ff;
  assign O_WREADY   = wrdy_ff;
  assign O_BVALID   = bv_ff;
  assign O_BRESP    = br_ff;
  assign O_ARREADY  = ardy_ff;
  assign O_RVALID   = rv_ff;
  assign O_RRESP    = rr_ff;
  assign O_RDATA    = rdat_ff;
  assign O_SAMPLE_CLK            = sclk_ff;
  assign O_SAMPLE_STROBE         = stb_ff;
  assign O_DUTY_CYCLE_STABILISER = out_ff[6];
  assign O_REFERENCE_ON          = out_ff[5];
  assign O_BIAS_ON               = out_ff[4];
  assign O_CLOCK_ON              = out_ff[3];
  assign O_OUTPUT_ENABLE         = out_ff[2];

  // Checks
  chk_pin_forces_down: assert property (@(posedge I_CLK) disable iff (I_RESET)
    I_POWER_DOWN_PIN |=> pwr_ff == PWR_DOWN)
    else $error("pin high did not power down");
  chk_outputs_off_down: assert property (@(posedge I_CLK) disable iff (I_RESET)
    pwr_ff == PWR_DOWN |=> !O_OUTPUT_ENABLE)
    else $error("outputs driven while down");
  chk_pin_low_leaves: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (pwr_ff == PWR_DOWN && !pwr_req && !stby_req) |=> pwr_ff == PWR_WAKE)
    else $error("pin low did not leave power-down");
  chk_ref_in_standby: assert property (@(posedge I_CLK) disable iff (I_RESET)
    pwr_ff == PWR_STANDBY |=> O_REFERENCE_ON)
    else $error("reference off in standby");
  chk_sync_resets_div: assert property (@(posedge I_CLK) disable iff (I_RESET)
    sync_take |=> cnt_ff == 3'h0 && !sclk_ff)
    else $error("sync did not reset divider");
  sequence s_sync_edge;
    !sy_ff[2] ##0 sy_ff[1];
  endsequence
  chk_sync_two_stage: assert property (@(posedge I_CLK) disable iff (I_RESET)
    sync_take |-> s_sync_edge and ($past(I_SYNC, 2)))
    else $error("sync acted without synchroniser delay");
  chk_once_disarms: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (sync_take && sync_bits[2] && !sync_wr) |=> !armed_ff)
    else $error("single sync mode stayed armed");
  chk_strobe_period: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (stb_ff && ratio_code == 3'h1 && ctl.clock_on && !sync_take)
      ##1 (ctl.clock_on && !sync_take && $stable(ratio_code)) |=> stb_ff)
    else $error("divide by two strobe period wrong");
  chk_strap_sets_stab: assert property (@(posedge I_CLK) disable iff (I_RESET)
    !stab_bits[1] |=> O_DUTY_CYCLE_STABILISER == $past(I_SERIAL_IO_STABILISER_STRAP))
    else $error("strap did not set stabiliser");
endmodule

// File: sim/scd_sync_src.sv
`timescale 1ns/1ps
module scd_sync_src
(
  // Clock and command
  input  wire logic i_clk,
  input  wire logic i_fire,
  // Sync level
  output logic      o_sync
);
  logic [2:0] left_ff = 3'h0;

  // Level launched just after a sample clock edge, held four cycles
  always_ff @(posedge i_clk)
  begin
    if (i_fire)
      left_ff <= 3'h4;
    else if (left_ff != 3'h0)
      left_ff <= left_ff - 3'h1;
  end
  assign o_sync = (left_ff != 3'h0);
endmodule

// File: sim/sample_clock_divider_sync_powerdown_bench.sv
`timescale 1ns/1ps
`include "scd_cfg.svh"
module sample_clock_divider_sync_powerdown_bench
  import scd_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, fire = 1'b0, pin = 1'b0, strap = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        awready, wready, bvalid, arready, rvalid, sync;
  logic        sclk, strobe, stab, ref_on, bias_on, clk_on, oen;
  logic [31:0] exp_q[$], msk_q[$];
  logic [1:0]  rsp_q[$];
  int          err_count = 0, tests_run = 0, cyc = 0, seed = 74;
  int          per, hi, t0, t1, ph0, ph, w1, w2, w3;

  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  scd_top dut (.I_CLK(clk), .I_RESET(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'h1), .I_WVALID(wvalid),
    .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(1'b1),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(1'b1), .I_SYNC(sync),
    .I_POWER_DOWN_PIN(pin), .I_SERIAL_IO_STABILISER_STRAP(strap), .O_SAMPLE_CLK(sclk),
    .O_SAMPLE_STROBE(strobe), .O_DUTY_CYCLE_STABILISER(stab), .O_REFERENCE_ON(ref_on),
    .O_BIAS_ON(bias_on), .O_CLOCK_ON(clk_on), .O_OUTPUT_ENABLE(oen));
  scd_sync_src src (.i_clk(clk), .i_fire(fire), .o_sync(sync));

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read results are compared here, oldest note first
  always @(posedge clk)
  begin
    if (rvalid === 1'b1 && exp_q.size() > 0)
    begin
      chk(rdata & msk_q.pop_front(), exp_q.pop_front());
      chk({30'h0, rresp}, {30'h0, rsp_q.pop_front()});
    end
  end

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] rsp);
    bit ad, wd;
    int n;
    ad = 0;
    wd = 0;
    n = 0;
    awaddr <= a;
    wdata <= {24'($random(seed)), d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd) && n < 100)
    begin
      @(posedge clk);
      n++;
      if (!ad && awready === 1'b1)
      begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1)
      begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    chk({30'h0, bresp}, {30'h0, rsp});
    chk(32'(n < 200), 32'h1);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] rsp);
    int n;
    n = 0;
    exp_q.push_back(e);
    msk_q.push_back(m);
    rsp_q.push_back(rsp);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1 && ++n < 100);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1 && ++n < 200);
    chk(32'(n < 200), 32'h1);
  endtask

  task automatic measure(output int p, output int h);
    int n;
    n = 0;
    do @(posedge clk); while (strobe !== 1'b1 && ++n < 50);
    p = 0;
    h = 0;
    do
    begin
      @(posedge clk);
      p++;
      h += (sclk === 1'b1);
    end
    while (strobe !== 1'b1 && p < 50);
  endtask

  // Phase of the divided strobe relative to a sync launched off grid by off
  task automatic sync_at(input int tref, input int off, output int t, output int p);
    int n;
    n = 0;
    while (off >= 0 && (cyc - tref) % 4 != off) @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    t = cyc;
    repeat (16) @(posedge clk);
    do @(posedge clk); while (strobe !== 1'b1 && ++n < 20);
    p = (cyc - t) % 4;
  endtask

  task automatic wake(output int w);
    w = 0;
    do @(posedge clk); while (clk_on !== 1'b1 && ++w < 3000);
  endtask

  task automatic pdown(input int d, output int w);
    pin <= 1'b1;
    repeat (3) @(posedge clk);
    chk({28'h0, oen, clk_on, ref_on, bias_on}, 32'h0);
    rd(`SCD_OFS_STATUS, {28'h0, PWR_DOWN, 2'h0}, 32'hc, 2'h0);
    repeat (d) @(posedge clk);
    pin <= 1'b0;
    wake(w);
    chk({31'h0, oen}, 32'h1);
  endtask

  initial
  begin
    #(50 * 20000);
    err_count++;
    conclude();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({28'h0, oen, clk_on, ref_on, bias_on}, 32'hf);
    rd(`SCD_OFS_DIVIDE, 32'h0, 32'hff, 2'h0);
    rd(`SCD_OFS_SYNC_CTRL, 32'h0, 32'hff, 2'h0);
    rd(`SCD_OFS_POWER, 32'h0, 32'hff, 2'h0);
    rd(`SCD_OFS_STATUS, 32'h0, 32'hf, 2'h0);
    rd(12'h010, 32'h0, 32'hffffffff, 2'h2);
    rd(12'h006, 32'h0, 32'hffffffff, 2'h2);
    wr(12'h010, 8'h01, 2'h2);
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 8; c++)
      begin
        strap <= s[0];
        wr(`SCD_OFS_DIVIDE, 8'(c), 2'h0);
        rd(`SCD_OFS_DIVIDE, 32'(c), 32'h7, 2'h0);
        repeat (`SCD_RELOCK_CYC) @(posedge clk);
        measure(per, hi);
        chk(32'(per), 32'(c + 1));
        chk(32'(hi), 32'((s == 1 && c > 0) ? (c + 1) / 2 : 1));
        chk({31'h0, stab}, {31'h0, s[0]});
      end
    wr(`SCD_OFS_STATUS, 8'h02, 2'h0);
    repeat (3) @(posedge clk);
    chk({31'h0, stab}, 32'h0);
    strap <= 1'b0;
    wr(`SCD_OFS_STATUS, 8'h03, 2'h0);
    repeat (3) @(posedge clk);
    chk({31'h0, stab}, 32'h1);
    rd(`SCD_OFS_STATUS, 32'h3, 32'h3, 2'h0);
    wr(`SCD_OFS_STATUS, 8'h00, 2'h0);
    wr(`SCD_OFS_DIVIDE, 8'h03, 2'h0);
    wr(`SCD_OFS_SYNC_CTRL, 8'h02, 2'h0);
    repeat (1 + ($unsigned($random(seed)) % 4)) @(posedge clk);
    sync_at(0, -1, t0, ph0);
    sync_at(t0, 1, t1, ph);
    chk(32'(ph), 32'(ph0));
    wr(`SCD_OFS_SYNC_CTRL, 8'h00, 2'h0);
    sync_at(t1, 1, t0, ph);
    chk(32'(ph), 32'((ph0 + 2) % 4));
    wr(`SCD_OFS_SYNC_CTRL, 8'h06, 2'h0);
    sync_at(t1, 1, t0, ph);
    chk(32'(ph), 32'(ph0));
    sync_at(t0, 1, t1, ph);
    chk(32'(ph), 32'((ph0 + 2) % 4));
    wr(`SCD_OFS_SYNC_CTRL, 8'h06, 2'h0);
    sync_at(t0, 1, t1, ph);
    chk(32'(ph), 32'(ph0));
    pdown(20, w1);
    pdown(200, w2);
    chk(32'(w2 > w1), 32'h1);
    wr(`SCD_OFS_POWER, 8'h01, 2'h0);
    repeat (3) @(posedge clk);
    chk({28'h0, oen, clk_on, ref_on, bias_on}, 32'h0);
    wr(`SCD_OFS_POWER, 8'h00, 2'h0);
    wake(w1);
    chk({31'h0, oen}, 32'h1);
    wr(`SCD_OFS_POWER, 8'h02, 2'h0);
    repeat (3) @(posedge clk);
    chk({30'h0, oen, ref_on}, 32'h1);
    rd(`SCD_OFS_STATUS, {28'h0, PWR_STANDBY, 2'h0}, 32'hc, 2'h0);
    repeat (200) @(posedge clk);
    wr(`SCD_OFS_POWER, 8'h00, 2'h0);
    wake(w3);
    chk(32'(w3 < w2), 32'h1);
    conclude();
  end
endmodule
